// ---- hssc_pkg.sv ----
package hssc_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ        = 40_000_000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int OC_FILT_NS    = 16_000;
	localparam int OL_FILT_NS    = 64_000;
	localparam int FILT_W        = 12;
	localparam logic [FILT_W-1:0] OC_CYC =
		FILT_W'((OC_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [FILT_W-1:0] OL_CYC =
		FILT_W'((OL_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ------------------------------------------------------------
	// pwm
	// ------------------------------------------------------------
	localparam int PWM_STEPS  = 256;
	localparam int FREQ_LO_HZ = 200;
	localparam int FREQ_HI_HZ = 400;
	localparam int PRESC_W    = 10;
	localparam logic [PRESC_W-1:0] PRESC_LO =
		PRESC_W'(CLK_HZ / (FREQ_LO_HZ * PWM_STEPS) - 1);
	localparam logic [PRESC_W-1:0] PRESC_HI =
		PRESC_W'(CLK_HZ / (FREQ_HI_HZ * PWM_STEPS) - 1);
	localparam int DUTY_W = 8;

	// ------------------------------------------------------------
	// channel configuration
	// ------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int CFG_W  = 3;
	localparam logic [CFG_W-1:0] CFG_OFF  = 3'h0;
	localparam logic [CFG_W-1:0] CFG_ON   = 3'h1;
	localparam logic [CFG_W-1:0] CFG_TMR1 = 3'h2;
	localparam logic [CFG_W-1:0] CFG_TMR2 = 3'h3;
	localparam logic [CFG_W-1:0] CFG_PWM1 = 3'h4;
	localparam logic [CFG_W-1:0] CFG_PWM2 = 3'h5;

	// ------------------------------------------------------------
	// chip operating modes
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_NORMAL   = 3'h0;
	localparam logic [2:0] MODE_STOP     = 3'h1;
	localparam logic [2:0] MODE_SLEEP    = 3'h2;
	localparam logic [2:0] MODE_RESTART  = 3'h3;
	localparam logic [2:0] MODE_FAILSAFE = 3'h4;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [NUM_CH*CFG_W-1:0] CFG_RST  = 12'h000;
	localparam logic [DUTY_W-1:0]       DUTY_RST = 8'h00;
	localparam logic [1:0]              FREQ_RST = 2'h0;

endpackage : hssc_pkg

// ---- hssc_ctrl.sv ----
`timescale 1ns/1ps
module hssc_ctrl
	import hssc_pkg::*;
(
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      arst_n,
	input  wire logic                      clk_en,
	// chip operating mode
	input  wire logic [2:0]                mode_code,
	// configuration writes
	input  wire logic                      cfg_wr,
	input  wire logic [NUM_CH*CFG_W-1:0]   cfg_wdata,
	input  wire logic                      duty1_wr,
	input  wire logic                      duty2_wr,
	input  wire logic [DUTY_W-1:0]         duty_wdata,
	input  wire logic                      freq_wr,
	input  wire logic [1:0]                freq_wdata,
	input  wire logic                      overvolt_shutdown_disable,
	input  wire logic                      undervolt_shutdown_disable,
	input  wire logic                      supply_fault_recovery_en,
	// flag clears
	input  wire logic [NUM_CH-1:0]         oc_flag_clr,
	input  wire logic [NUM_CH-1:0]         ol_flag_clr,
	// timers
	input  wire logic                      timer1_in,
	input  wire logic                      timer2_in,
	// analog indications
	input  wire logic                      supply_ov_ind,
	input  wire logic                      supply_uv_ind,
	input  wire logic [NUM_CH-1:0]         oc_ind,
	input  wire logic [NUM_CH-1:0]         ol_ind,
	// outputs
	output logic      [NUM_CH-1:0]         high_side_output,
	output logic      [2*CFG_W-1:0]        output_cfg_reg_a,
	output logic      [2*CFG_W-1:0]        output_cfg_reg_b,
	output logic      [DUTY_W-1:0]         duty_reg_gen1,
	output logic      [DUTY_W-1:0]         duty_reg_gen2,
	output logic      [1:0]                pwm_frequency_select_reg,
	output logic                           switch_supply_overvolt_flag,
	output logic                           switch_supply_undervolt_flag,
	output logic      [NUM_CH-1:0]         overcurrent_status_reg,
	output logic      [NUM_CH-1:0]         open_load_status_reg
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic drive_of(input logic [CFG_W-1:0] c,
		input logic t1, input logic t2, input logic p1, input logic p2);
		logic d;
		d = 1'b0;
		case (c)
			CFG_ON:   d = 1'b1;
			CFG_TMR1: d = t1;
			CFG_TMR2: d = t2;
			CFG_PWM1: d = p1;
			CFG_PWM2: d = p2;
			default:  d = 1'b0;
		endcase
		return d;
	endfunction : drive_of

	function automatic logic [FILT_W-1:0] filt_next(
		input logic [FILT_W-1:0] cnt, input logic active,
		input logic [FILT_W-1:0] lim);
		logic [FILT_W-1:0] n;
		n = '0;
		if (active && cnt < lim) begin
			n = cnt + 1'b1;
		end else if (active) begin
			n = cnt;
		end
		return n;
	endfunction : filt_next

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [NUM_CH*2+1:0] sync1_r;
	logic [NUM_CH*2+1:0] sync2_r;
	logic                ov_s;
	logic                uv_s;
	logic [NUM_CH-1:0]   oc_s;
	logic [NUM_CH-1:0]   ol_s;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else if (clk_en) begin
			sync1_r <= {supply_ov_ind, supply_uv_ind, oc_ind, ol_ind};
			sync2_r <= sync1_r;
		end
	end

	assign ov_s = sync2_r[NUM_CH*2+1];
	assign uv_s = sync2_r[NUM_CH*2];
	assign oc_s = sync2_r[NUM_CH*2-1:NUM_CH];
	assign ol_s = sync2_r[NUM_CH-1:0];

	// ------------------------------------------------------------
	// mode and supply fault tracking
	// ------------------------------------------------------------
	logic [2:0] mode_prev_r;
	logic       supply_sd_r;
	logic       forced_off;
	logic       force_entry;
	logic       supply_sd;
	logic       supply_release;
	logic       cfg_open;

	assign forced_off  = (mode_code == MODE_RESTART) ||
		(mode_code == MODE_FAILSAFE);
	assign force_entry = forced_off && (mode_prev_r != mode_code);
	assign cfg_open    = (mode_code == MODE_NORMAL);
	assign supply_sd = (ov_s && !overvolt_shutdown_disable) ||
		(uv_s && !undervolt_shutdown_disable);
	assign supply_release = supply_sd_r && !supply_sd;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_prev_r <= MODE_NORMAL;
			supply_sd_r <= 1'b0;
		end else if (clk_en) begin
			mode_prev_r <= mode_code;
			supply_sd_r <= supply_sd;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			switch_supply_overvolt_flag  <= 1'b0;
			switch_supply_undervolt_flag <= 1'b0;
		end else if (clk_en) begin
			switch_supply_overvolt_flag  <= ov_s;
			switch_supply_undervolt_flag <= uv_s;
		end
	end

	// ------------------------------------------------------------
	// pwm generators
	// ------------------------------------------------------------
	logic [DUTY_W-1:0]  duty1_r;
	logic [DUTY_W-1:0]  duty2_r;
	logic [1:0]         freq_r;
	logic [PRESC_W-1:0] presc_r [2];
	logic [DUTY_W-1:0]  step_r  [2];
	logic [1:0]         pwm_out;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			duty1_r <= DUTY_RST;
			duty2_r <= DUTY_RST;
			freq_r  <= FREQ_RST;
		end else if (clk_en && cfg_open) begin
			if (duty1_wr) begin
				duty1_r <= duty_wdata;
			end
			if (duty2_wr) begin
				duty2_r <= duty_wdata;
			end
			if (freq_wr) begin
				freq_r <= freq_wdata;
			end
		end
	end

	// free-running so an assignment starts pwm at once
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int g = 0; g < 2; g++) begin
				presc_r[g] <= '0;
				step_r[g]  <= '0;
			end
		end else if (clk_en) begin
			for (int g = 0; g < 2; g++) begin
				if (presc_r[g] >= (freq_r[g] ? PRESC_HI : PRESC_LO)) begin
					presc_r[g] <= '0;
					step_r[g]  <= step_r[g] + 1'b1;
				end else begin
					presc_r[g] <= presc_r[g] + 1'b1;
				end
			end
		end
	end

	assign pwm_out[0] = step_r[0] < duty1_r;
	assign pwm_out[1] = step_r[1] < duty2_r;

	// ------------------------------------------------------------
	// protection filters
	// ------------------------------------------------------------
	logic [FILT_W-1:0] oc_cnt_r [NUM_CH];
	logic [FILT_W-1:0] ol_cnt_r [NUM_CH];
	logic [NUM_CH-1:0] oc_trip;
	logic [NUM_CH-1:0] ol_trip;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int c = 0; c < NUM_CH; c++) begin
				oc_cnt_r[c] <= '0;
				ol_cnt_r[c] <= '0;
			end
		end else if (clk_en) begin
			for (int c = 0; c < NUM_CH; c++) begin
				oc_cnt_r[c] <= filt_next(oc_cnt_r[c],
					oc_s[c] && high_side_output[c], OC_CYC);
				ol_cnt_r[c] <= filt_next(ol_cnt_r[c],
					ol_s[c] && high_side_output[c], OL_CYC);
			end
		end
	end

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			oc_trip[c] = (oc_cnt_r[c] >= OC_CYC) && oc_s[c] &&
				high_side_output[c];
			ol_trip[c] = (ol_cnt_r[c] >= OL_CYC) && ol_s[c] &&
				high_side_output[c];
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			overcurrent_status_reg <= '0;
			open_load_status_reg   <= '0;
		end else if (clk_en) begin
			overcurrent_status_reg <=
				(overcurrent_status_reg & ~oc_flag_clr) | oc_trip;
			open_load_status_reg <=
				(open_load_status_reg & ~ol_flag_clr) | ol_trip;
		end
	end

	// ------------------------------------------------------------
	// channel configuration
	// ------------------------------------------------------------
	logic [NUM_CH*CFG_W-1:0] cfg_r;
	logic [NUM_CH*CFG_W-1:0] cfg_nxt;

	always_comb begin
		cfg_nxt = cfg_r;
		if (cfg_wr && cfg_open) begin
			cfg_nxt = cfg_wdata;
		end
		if (supply_release && !supply_fault_recovery_en) begin
			cfg_nxt = CFG_RST;
		end
		if (force_entry) begin
			cfg_nxt = CFG_RST;
		end
		for (int c = 0; c < NUM_CH; c++) begin
			if (oc_trip[c]) begin
				cfg_nxt[c*CFG_W +: CFG_W] = CFG_OFF;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_r <= CFG_RST;
		end else if (clk_en) begin
			cfg_r <= cfg_nxt;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			output_cfg_reg_a         <= '0;
			output_cfg_reg_b         <= '0;
			duty_reg_gen1            <= DUTY_RST;
			duty_reg_gen2            <= DUTY_RST;
			pwm_frequency_select_reg <= FREQ_RST;
		end else if (clk_en) begin
			output_cfg_reg_a         <= cfg_nxt[2*CFG_W-1:0];
			output_cfg_reg_b         <= cfg_nxt[4*CFG_W-1:2*CFG_W];
			duty_reg_gen1            <= duty1_r;
			duty_reg_gen2            <= duty2_r;
			pwm_frequency_select_reg <= freq_r;
		end
	end

	// ------------------------------------------------------------
	// output drive
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			high_side_output <= '0;
		end else if (clk_en) begin
			for (int c = 0; c < NUM_CH; c++) begin
				high_side_output[c] <= !forced_off && !supply_sd &&
					drive_of(cfg_nxt[c*CFG_W +: CFG_W], timer1_in,
						timer2_in, pwm_out[0], pwm_out[1]);
			end
		end
	end

endmodule : hssc_ctrl

// ---- hssc_chk_properties.sv ----
`timescale 1ns/1ps
module hssc_chk
	import hssc_pkg::*;
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        arst_n,
	// controls
	input wire logic [2:0]  mode_code,
	input wire logic        cfg_wr,
	input wire logic [11:0] cfg_wdata,
	input wire logic        overvolt_shutdown_disable,
	input wire logic        undervolt_shutdown_disable,
	input wire logic [3:0]  oc_flag_clr,
	input wire logic [3:0]  ol_flag_clr,
	// observed
	input wire logic [3:0]  high_side_output,
	input wire logic [5:0]  output_cfg_reg_a,
	input wire logic [5:0]  output_cfg_reg_b,
	input wire logic [7:0]  duty_reg_gen2,
	input wire logic        switch_supply_overvolt_flag,
	input wire logic        switch_supply_undervolt_flag,
	input wire logic [3:0]  overcurrent_status_reg,
	input wire logic [3:0]  open_load_status_reg
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	wire forced = mode_code == MODE_RESTART || mode_code == MODE_FAILSAFE;
	// three cycles cover the sync and output register latency
	sequence ov_hold;
		(switch_supply_overvolt_flag && !overvolt_shutdown_disable)[*3];
	endsequence
	sequence uv_hold;
		(switch_supply_undervolt_flag && !undervolt_shutdown_disable)[*3];
	endsequence
	a_forced_off: assert property (
		forced && $past(forced) |-> high_side_output == 4'h0)
		else $error("output on in forced-off mode");
	a_cfg_write: assert property (
		cfg_wr && mode_code == MODE_NORMAL && !switch_supply_overvolt_flag
		&& !switch_supply_undervolt_flag
		|=> {output_cfg_reg_b, output_cfg_reg_a} == $past(cfg_wdata))
		else $error("config write not taken");
	a_oc_sticky: assert property (
		($past(overcurrent_status_reg) & ~$past(oc_flag_clr)
		& ~overcurrent_status_reg) == 4'h0)
		else $error("overcurrent flag lost");
	a_ol_sticky: assert property (
		($past(open_load_status_reg) & ~$past(ol_flag_clr)
		& ~open_load_status_reg) == 4'h0)
		else $error("open-load flag lost");
	a_oc_trip_off: assert property (
		$rose(overcurrent_status_reg[0]) |-> ##[0:2]
		(!high_side_output[0] && output_cfg_reg_a[2:0] == CFG_OFF))
		else $error("overcurrent trip left channel on");
	a_ol_stays_on: assert property (
		$rose(open_load_status_reg[0]) && output_cfg_reg_a[2:0] == CFG_ON
		|-> high_side_output[0] ##1 high_side_output[0])
		else $error("open load switched channel off");
	a_ov_shut_off: assert property (
		ov_hold |-> high_side_output == 4'h0)
		else $error("output on during overvoltage");
	a_uv_shut_off: assert property (
		uv_hold |-> high_side_output == 4'h0)
		else $error("output on during undervoltage");
	a_pwm_zero: assert property (
		(output_cfg_reg_b[5:3] == CFG_PWM2 && duty_reg_gen2 == 8'h00)[*3]
		|-> !high_side_output[3])
		else $error("zero duty drove output");
endmodule : hssc_chk

bind hssc_ctrl hssc_chk i_hssc_chk (.sys_clk, .arst_n, .mode_code, .cfg_wr,
	.cfg_wdata, .overvolt_shutdown_disable, .undervolt_shutdown_disable,
	.oc_flag_clr, .ol_flag_clr, .high_side_output, .output_cfg_reg_a,
	.output_cfg_reg_b, .duty_reg_gen2, .switch_supply_overvolt_flag,
	.switch_supply_undervolt_flag, .overcurrent_status_reg,
	.open_load_status_reg);

// ---- hssc_load.sv ----
`timescale 1ns/1ps
module hssc_load
(
	// switch drive
	input  wire logic [3:0] high_side_output,
	// fault selection
	input  wire logic [3:0] short_en,
	input  wire logic [3:0] open_en,
	// current sense
	output logic      [3:0] oc_ind,
	output logic      [3:0] ol_ind
);
	// a load only draws current while its switch conducts
	assign oc_ind = high_side_output & short_en;
	assign ol_ind = high_side_output & open_en;
endmodule : hssc_load

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top
	import hssc_pkg::*;
;
	logic        sys_clk, arst_n, cfg_wr, duty1_wr, duty2_wr, freq_wr;
	logic        overvolt_shutdown_disable, undervolt_shutdown_disable;
	logic        supply_fault_recovery_en, timer1_in, timer2_in;
	logic        supply_ov_ind, supply_uv_ind;
	logic        switch_supply_overvolt_flag, switch_supply_undervolt_flag;
	logic [2:0]  mode_code;
	logic [11:0] cfg_wdata;
	logic [7:0]  duty_wdata, duty_reg_gen1, duty_reg_gen2;
	logic [1:0]  freq_wdata, pwm_frequency_select_reg;
	logic [3:0]  oc_flag_clr, ol_flag_clr, oc_ind, ol_ind, short_en, open_en;
	logic [3:0]  high_side_output, overcurrent_status_reg, open_load_status_reg;
	logic [5:0]  output_cfg_reg_a, output_cfg_reg_b;
	int          errors, total_checks, n1, n2;
	// {ov, uv, ov disable, uv disable, recovery, expected outputs}
	logic [8:0]  sup [6] = '{9'h110, 9'h01F, 9'h15F, 9'h0BF, 9'h090, 9'h000};
	wire  [11:0] cfg_rb = {output_cfg_reg_b, output_cfg_reg_a};
	wire  [11:0] hso    = 12'(high_side_output);
	wire  [11:0] flags  = {2'h0, switch_supply_overvolt_flag,
		switch_supply_undervolt_flag, overcurrent_status_reg,
		open_load_status_reg};

	hssc_ctrl i_hssc_ctrl (.sys_clk, .arst_n, .clk_en(1'b1), .mode_code,
		.cfg_wr, .cfg_wdata, .duty1_wr, .duty2_wr, .duty_wdata, .freq_wr,
		.freq_wdata, .overvolt_shutdown_disable, .undervolt_shutdown_disable,
		.supply_fault_recovery_en, .oc_flag_clr, .ol_flag_clr, .timer1_in,
		.timer2_in, .supply_ov_ind, .supply_uv_ind, .oc_ind, .ol_ind,
		.high_side_output, .output_cfg_reg_a, .output_cfg_reg_b,
		.duty_reg_gen1, .duty_reg_gen2, .pwm_frequency_select_reg,
		.switch_supply_overvolt_flag, .switch_supply_undervolt_flag,
		.overcurrent_status_reg, .open_load_status_reg);
	hssc_load i_hssc_load (.high_side_output, .short_en, .open_en, .oc_ind,
		.ol_ind);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask : pulse
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{cfg_wr, duty1_wr, duty2_wr, freq_wr, timer1_in, timer2_in} = '0;
		{overvolt_shutdown_disable, undervolt_shutdown_disable} = '0;
		{supply_fault_recovery_en, supply_ov_ind, supply_uv_ind} = '0;
		{mode_code, cfg_wdata, duty_wdata, freq_wdata} = '0;
		{oc_flag_clr, ol_flag_clr, short_en, open_en} = '0;
		errors = 0;
		total_checks = 0;
		arst_n = 1'b0;
		tick(6);
		arst_n = 1'b1;
		tick(1);
		chk(cfg_rb | hso, 12'h000);
		timer1_in = 1'b1;
		cfg_wdata = {CFG_OFF, CFG_TMR2, CFG_TMR1, CFG_ON};
		pulse(cfg_wr);
		chk(cfg_rb, cfg_wdata);
		chk(hso, 12'h003);
		timer2_in = 1'b1;
		tick(2);
		chk(hso, 12'h007);
		mode_code = MODE_STOP;
		cfg_wdata = 12'h000;
		duty_wdata = 8'h55;
		pulse(cfg_wr);
		pulse(duty1_wr);
		chk(cfg_rb, 12'h0D1);
		chk(12'(duty_reg_gen1) | hso, 12'h007);
		mode_code = MODE_RESTART;
		tick(3);
		chk(hso | cfg_rb, 12'h000);
		cfg_wdata = {4{CFG_ON}};
		pulse(cfg_wr);
		mode_code = MODE_FAILSAFE;
		tick(3);
		chk(hso | cfg_rb, 12'h000);
		mode_code = MODE_NORMAL;
		pulse(cfg_wr);
		chk(hso, 12'h00F);
		foreach (sup[i]) begin
			{supply_ov_ind, supply_uv_ind, overvolt_shutdown_disable,
				undervolt_shutdown_disable, supply_fault_recovery_en} = sup[i][8:4];
			tick(5);
			chk(hso, 12'(sup[i][3:0]));
			chk(flags, {2'h0, sup[i][8:7], 8'h00});
		end
		chk(cfg_rb, 12'h000);
		pulse(cfg_wr);
		mode_code = MODE_SLEEP;
		short_en = 4'h1;
		tick(600);
		chk(flags, 12'h000);
		tick(60);
		chk(flags, 12'h010);
		chk(cfg_rb | hso, 12'h24E);
		short_en = 4'h0;
		tick(20);
		chk(flags, 12'h010);
		oc_flag_clr = 4'h1;
		tick(1);
		oc_flag_clr = 4'h0;
		tick(1);
		chk(flags, 12'h000);
		mode_code = MODE_NORMAL;
		pulse(cfg_wr);
		chk(hso, 12'h00F);
		// open load tried on steady drive
		open_en = 4'h1;
		tick(2500);
		chk(flags, 12'h000);
		tick(100);
		chk(flags, 12'h001);
		chk(hso, 12'h00F);
		open_en = 4'h0;
		tick(20);
		chk(flags, 12'h001);
		ol_flag_clr = 4'h1;
		tick(1);
		ol_flag_clr = 4'h0;
		tick(1);
		chk(flags, 12'h000);
		cfg_wdata = 12'hFB6;
		pulse(cfg_wr);
		chk(cfg_rb, 12'hFB6);
		chk(hso, 12'h000);
		duty_wdata = 8'hFF;
		pulse(duty1_wr);
		duty_wdata = 8'h3C;
		pulse(duty2_wr);
		chk(12'(duty_reg_gen2), 12'h03C);
		duty_wdata = 8'h00;
		pulse(duty2_wr);
		freq_wdata = 2'h1;
		pulse(freq_wr);
		chk({duty_reg_gen1, 2'h0, pwm_frequency_select_reg}, 12'hFF1);
		cfg_wdata = {CFG_PWM2, CFG_ON, CFG_ON, CFG_PWM1};
		pulse(cfg_wr);
		n1 = 0;
		n2 = 0;
		// one 400 Hz step is 390 cycles, so full duty is low at most that long
		repeat (1000) begin
			tick(1);
			n1 += high_side_output[0];
			n2 += high_side_output[3];
		end
		chk(12'(n1 >= 608), 12'h001);
		chk(12'(n2), 12'h000);
		final_report();
	end

	// tests need about 4400 cycles
	initial begin
		#(25 * 20000);
		errors++;
		final_report();
	end
endmodule : tb_top
